// *** rtl/acp_pkg.sv ***
// Package for the arithmetic co-processor: register map and timing counts.
// Assumes an 8-bit core special-function-register bus with 8-bit addresses.
package acp_pkg;
	//------------------------------------------------------------
	// Register addresses
	//------------------------------------------------------------
	localparam logic [7:0] ADDR_OPB0 = 8'he9;
	localparam logic [7:0] ADDR_OPB1 = 8'hea;
	localparam logic [7:0] ADDR_OPB2 = 8'heb;
	localparam logic [7:0] ADDR_OPB3 = 8'hec;
	localparam logic [7:0] ADDR_OPB4 = 8'hed;
	localparam logic [7:0] ADDR_OPB5 = 8'hc7;
	localparam logic [7:0] ADDR_ARITH_CTRL = 8'hef;
	//------------------------------------------------------------
	// Control field layout and reset
	//------------------------------------------------------------
	localparam int CTRL_ERR_BIT = 7;
	localparam int CTRL_OVF_BIT = 6;
	localparam int CTRL_DIR_BIT = 5;
	localparam int CTRL_CNT_MSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	//------------------------------------------------------------
	// Execution times in cycles
	//------------------------------------------------------------
	localparam logic [4:0] CYC_DIV32 = 5'h11;
	localparam logic [4:0] CYC_DIV16 = 5'h09;
	localparam logic [4:0] CYC_MUL = 5'h0b;
	localparam logic [4:0] CYC_SHIFT_BASE = 5'h02;
	localparam logic [4:0] CYC_NORM_BASE = 5'h03;
	typedef enum logic [2:0] {
		ACP_OP_NONE = 3'h0,
		ACP_OP_DIV32 = 3'h1,
		ACP_OP_DIV16 = 3'h2,
		ACP_OP_MUL = 3'h3,
		ACP_OP_SHIFT = 3'h4,
		ACP_OP_NORM = 3'h5
	} acp_op_e;
	// Phase sequence: idle, loading, running, results ready
	typedef enum logic [1:0] {
		ACP_IDLE = 2'b00,
		ACP_LOAD = 2'b01,
		ACP_RUN = 2'b11,
		ACP_DONE = 2'b10
	} acp_phase_e;
endpackage : acp_pkg

// *** rtl/acp_coproc.sv ***
// Multiply, divide, shift and normalize co-processor beside an 8-bit core.
// Assumes one-cycle read and write strobes from the core on its own clock.
// Operation
// - Writing operand byte 0 always opens a new loading phase.
// - Byte 2 or 3 written before byte 5 selects 32/16 division.
// - Byte 4 selects 16/16 division, byte 1 selects 16x16 multiply.
// - Byte 5 write or control write starts the chosen operation.
// - Calculation runs on its own while the core continues.
// - Divisions take 17 and 9 cycles, multiplication 11 cycles.
// - Shift takes two cycles plus half the count, 3 to 18.
// - Normalize takes three cycles plus half the shifts, 3 to 19.
// - Control bit 7 is the error flag for accesses that disturb a running calculation.
// - Control bit 6 is the overflow flag of the last operation.
// - Control bit 5 picks shift direction, 1 means right.
// - Zero count selects normalize, otherwise shift by that count.
// - Normalize shifts left until top bit set, stores shift count.
// - Shifts move bytes 0..3, filling with zeros.
// - Final result read ends calculation: byte 5 or byte 3.
// - Error detection armed by byte 0 write, disarmed by final read.
// - Any register write while running sets error; byte 0..4 writes return to loading, byte 5 and control writes restart.
// - Operand read while running and armed sets error, no abort.
// - Error flag clears only on control read, writes never clear it.
// - Overflow on divide by zero, product over 16 bits, normalized input.
// - Other operations clear overflow; software cannot write it.
// - Unsigned arithmetic; results overwrite operands.
`timescale 1ns/100ps
module acp_coproc
	import acp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic busy_o
);
	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		logic [5:0][7:0] opb;
		logic err;
		logic ovf;
		logic dir;
		logic [4:0] cnt;
		acp_phase_e phase;
		acp_op_e op;
		logic armed;
		logic [4:0] timer;
		logic [7:0] rdata;
		logic [4:0] runlen;
		logic busy;
	} acp_state_s;
	acp_state_s q, d;

	function automatic logic [4:0] acp_lead_zeros(input logic [31:0] v);
		logic [4:0] n;
		n = 5'h1f;
		for (int i = 0; i < 32; i++)
		begin
			if (v[i])
				n = 5'(31 - i);
		end
		return n;
	endfunction : acp_lead_zeros

	// Shifter moves two bits a cycle, so run time grows by half the count
	function automatic logic [4:0] acp_half_steps(input logic [4:0] c);
		return 5'(({1'b0, c} + 6'h01) >> 1);
	endfunction : acp_half_steps

	logic [31:0] val32;
	logic [15:0] dvs16;
	logic [15:0] dvd16;
	logic [31:0] prod;
	logic [4:0] lz;
	logic is_opb_wr;
	logic is_opb_rd;
	logic last_rd;
	assign val32 = {q.opb[3], q.opb[2], q.opb[1], q.opb[0]};
	assign dvs16 = {q.opb[5], q.opb[4]};
	assign dvd16 = {q.opb[1], q.opb[0]};
	assign prod = {16'h0000, dvd16} * {16'h0000, dvs16};
	assign lz = acp_lead_zeros(val32);
	assign is_opb_wr = wr_i && (addr_i == ADDR_OPB0 || addr_i == ADDR_OPB1
		|| addr_i == ADDR_OPB2 || addr_i == ADDR_OPB3
		|| addr_i == ADDR_OPB4 || addr_i == ADDR_OPB5);
	assign is_opb_rd = rd_i && (addr_i == ADDR_OPB0 || addr_i == ADDR_OPB1
		|| addr_i == ADDR_OPB2 || addr_i == ADDR_OPB3
		|| addr_i == ADDR_OPB4 || addr_i == ADDR_OPB5);
	// Division ends on byte 5, everything else on byte 3
	assign last_rd = rd_i && q.phase == ACP_DONE &&
		(((q.op == ACP_OP_DIV32 || q.op == ACP_OP_DIV16)
		&& addr_i == ADDR_OPB5) ||
		((q.op == ACP_OP_MUL || q.op == ACP_OP_SHIFT
		|| q.op == ACP_OP_NORM) && addr_i == ADDR_OPB3));

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb
	begin
		logic running;
		running = 1'b0;
		d = q;
		running = (q.phase == ACP_RUN);
		// Read data: registered so the output comes from a flip-flop
		d.rdata = 8'h00;
		if (rd_i)
		begin
			case (addr_i)
				ADDR_OPB0: d.rdata = q.opb[0];
				ADDR_OPB1: d.rdata = q.opb[1];
				ADDR_OPB2: d.rdata = q.opb[2];
				ADDR_OPB3: d.rdata = q.opb[3];
				ADDR_OPB4: d.rdata = q.opb[4];
				ADDR_OPB5: d.rdata = q.opb[5];
				ADDR_ARITH_CTRL: d.rdata = {q.err, q.ovf, q.dir, q.cnt};
				default: d.rdata = 8'h00;
			endcase
		end
		// Control read clears the error flag; a set in the same cycle wins
		if (rd_i && addr_i == ADDR_ARITH_CTRL)
			d.err = 1'b0;
		if (is_opb_rd && running && q.armed)
			d.err = 1'b1;
		if (last_rd)
		begin
			d.armed = 1'b0;
			d.phase = ACP_IDLE;
		end
		// Computation: results land on the final cycle of the run time
		if (running)
		begin
			d.timer = q.timer - 5'h01;
			if (q.timer == 5'h01)
			begin
				d.phase = ACP_DONE;
				case (q.op)
					ACP_OP_DIV32:
					begin
						if (dvs16 != 16'h0000)
						begin
							{d.opb[3], d.opb[2], d.opb[1], d.opb[0]} =
								val32 / {16'h0000, dvs16};
							{d.opb[5], d.opb[4]} =
								16'(val32 % {16'h0000, dvs16});
						end
					end
					ACP_OP_DIV16:
					begin
						if (dvs16 != 16'h0000)
						begin
							{d.opb[1], d.opb[0]} = dvd16 / dvs16;
							{d.opb[5], d.opb[4]} = dvd16 % dvs16;
						end
					end
					ACP_OP_MUL:
						{d.opb[3], d.opb[2], d.opb[1], d.opb[0]} = prod;
					ACP_OP_SHIFT:
					begin
						if (q.dir)
							{d.opb[3], d.opb[2], d.opb[1], d.opb[0]} =
								val32 >> q.cnt;
						else
							{d.opb[3], d.opb[2], d.opb[1], d.opb[0]} =
								val32 << q.cnt;
					end
					ACP_OP_NORM:
					begin
						{d.opb[3], d.opb[2], d.opb[1], d.opb[0]} =
							val32 << q.cnt;
					end
					default: d.phase = ACP_DONE;
				endcase
			end
		end
		// Writes: any write during a run flags an error; byte 0..4 writes drop back to loading, byte 5 and control writes restart a run
		if (wr_i && running && (is_opb_wr || addr_i == ADDR_ARITH_CTRL))
		begin
			d.err = 1'b1;
			d.phase = ACP_LOAD;
			d.timer = 5'h00;
		end
		if (is_opb_wr)
		begin
			case (addr_i)
				ADDR_OPB0:
				begin
					d.opb[0] = wdata_i;
					d.phase = ACP_LOAD;
					d.op = ACP_OP_NONE;
					d.armed = 1'b1;
				end
				ADDR_OPB1:
				begin
					d.opb[1] = wdata_i;
					// The later of byte 1 and byte 4 picks the 16-bit operation
					if (d.op != ACP_OP_DIV32)
						d.op = ACP_OP_MUL;
				end
				ADDR_OPB2:
				begin
					d.opb[2] = wdata_i;
					d.op = ACP_OP_DIV32;
				end
				ADDR_OPB3:
				begin
					d.opb[3] = wdata_i;
					d.op = ACP_OP_DIV32;
				end
				ADDR_OPB4:
				begin
					d.opb[4] = wdata_i;
					if (d.op != ACP_OP_DIV32)
						d.op = ACP_OP_DIV16;
				end
				ADDR_OPB5:
				begin
					d.opb[5] = wdata_i;
					if (d.phase == ACP_LOAD && d.op != ACP_OP_NONE)
					begin
						d.phase = ACP_RUN;
						// Overflow is decided from the loaded operands
						case (d.op)
							ACP_OP_MUL:
							begin
								d.timer = CYC_MUL;
								d.ovf = ({16'h0000, wdata_i, q.opb[4]}
									* {16'h0000, dvd16})
									> 32'h0000ffff;
							end
							ACP_OP_DIV16:
							begin
								d.timer = CYC_DIV16;
								d.ovf = {wdata_i, q.opb[4]} == 16'h0000;
							end
							default:
							begin
								d.op = ACP_OP_DIV32;
								d.timer = CYC_DIV32;
								d.ovf = {wdata_i, q.opb[4]} == 16'h0000;
							end
						endcase
					end
				end
				default: d.opb[0] = q.opb[0];
			endcase
		end
		// Control write starts shift or normalize; flags stay hardware-owned
		if (wr_i && addr_i == ADDR_ARITH_CTRL)
		begin
			d.dir = wdata_i[CTRL_DIR_BIT];
			d.cnt = wdata_i[CTRL_CNT_MSB:0];
			d.phase = ACP_RUN;
			d.ovf = 1'b0;
			if (wdata_i[CTRL_CNT_MSB:0] == 5'h00)
			begin
				d.op = ACP_OP_NORM;
				d.cnt = lz;
				d.ovf = val32[31];
				d.timer = CYC_NORM_BASE + acp_half_steps(lz);
			end
			else
			begin
				d.op = ACP_OP_SHIFT;
				d.timer = CYC_SHIFT_BASE
					+ acp_half_steps(wdata_i[CTRL_CNT_MSB:0]);
			end
		end
		// Run length kept only for the timing checks below
		if (running && !wr_i)
			d.runlen = q.runlen + 5'h01;
		else if (d.phase == ACP_RUN)
			d.runlen = 5'h00;
		d.busy = (d.phase == ACP_RUN);
		if (!rstn_i)
		begin
			d.runlen = 5'h00;
			d.busy = 1'b0;
			d.err = CTRL_RESET[CTRL_ERR_BIT];
			d.ovf = CTRL_RESET[CTRL_OVF_BIT];
			d.dir = CTRL_RESET[CTRL_DIR_BIT];
			d.cnt = CTRL_RESET[CTRL_CNT_MSB:0];
			d.phase = ACP_IDLE;
			d.op = ACP_OP_NONE;
			d.armed = 1'b0;
			d.timer = 5'h00;
			d.rdata = 8'h00;
		end
	end

	always_ff @(posedge clk_i)
	begin
		q <= d;
	end

	assign rdata_o = q.rdata;
	assign busy_o = q.busy;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	div32_time_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		($fell(busy_o) && q.phase == ACP_DONE && q.op == ACP_OP_DIV32)
		|-> q.runlen == 5'h11)
		else $error("32/16 divide did not take 17 cycles");
	mul_time_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		($fell(busy_o) && q.phase == ACP_DONE && q.op == ACP_OP_MUL)
		|-> q.runlen == 5'h0b)
		else $error("multiply did not take 11 cycles");
	write_err_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(busy_o && wr_i && (is_opb_wr || addr_i == ADDR_ARITH_CTRL))
		|=> q.err)
		else $error("write during run did not flag error");
	read_err_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(busy_o && q.armed && is_opb_rd && !wr_i)
		|=> q.err && (busy_o || q.phase == ACP_DONE))
		else $error("read during run mishandled");
	err_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(q.err && !(rd_i && addr_i == ADDR_ARITH_CTRL)) |=> q.err)
		else $error("error flag dropped without control read");
	arm_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(last_rd && !wr_i) |=> !q.armed)
		else $error("final read did not disarm detection");
	norm_ovf_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && addr_i == ADDR_ARITH_CTRL && wdata_i[4:0] == 5'h00)
		|=> q.ovf == $past(val32[31]))
		else $error("normalize overflow wrong");
	shift_time_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && addr_i == ADDR_ARITH_CTRL && wdata_i[4:0] == 5'h01)
		##1 (!wr_i)[*3] |=> q.phase == ACP_DONE)
		else $error("shift by one not done in 3 cycles");
	start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && addr_i == ADDR_ARITH_CTRL) |=> busy_o)
		else $error("control write did not start operation");
endmodule : acp_coproc

// *** bench/acp_core_model.sv ***
// Core-side model: drives register strobes of the co-processor.
// Assumes each task is entered at a rising edge of clk_i.
`timescale 1ns/100ps
module acp_core_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o
);
	initial
	begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// Idle cycle after each access so a strobe is never set twice at one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		addr_o <= ~a;
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rdata_i;
	endtask : rd
endmodule : acp_core_model

// *** bench/multiply_divide_coprocessor_tb_top.sv ***
// Self-checking bench: integer model of the co-processor vs the design.
// Assumes the core model above as the only bus driver.
`timescale 1ns/100ps
module multiply_divide_coprocessor_tb_top
	import acp_pkg::*;
;
	logic clk_i, rstn_i, wr, rd, busy;
	logic [7:0] addr, wdata, rdata, m_ctrl, got, ctl;
	logic [7:0] m [6];
	logic [7:0] addrs [6];
	int n_fail, checks, busy_cnt, seed, t, op;
	acp_coproc dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wr_i(wr),
		.rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .busy_o(busy));
	acp_core_model core (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
		.wr_o(wr), .rd_o(rd), .wdata_o(wdata));
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
		if (busy === 1'b1)
			busy_cnt <= busy_cnt + 1;
	//------------------------------------------------------------
	// Checks and verdict
	//------------------------------------------------------------
	task automatic give_verdict();
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk_byte
	task automatic chk_cyc(input int g, input int e);
		checks++;
		if (g != e)
		begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk_cyc
	// Bounded wait; a hang ends the run as a failure
	task automatic wait_idle();
		int k;
		for (k = 0; k < 40; k++)
		begin
			#1;
			if (busy === 1'b0)
				break;
			@(posedge clk_i);
		end
		if (k == 40)
		begin
			n_fail++;
			give_verdict();
		end
		@(posedge clk_i);
	endtask : wait_idle
	//------------------------------------------------------------
	// One operation: load, start, optional poke, check everything
	//------------------------------------------------------------
	task automatic run_op(input int poke);
		int wseq[$];
		int rseq[$];
		int cyc;
		int k;
		logic [31:0] v;
		logic [15:0] dv;
		case (op)
			1: wseq = '{0, 1, 2, 3, 4};
			2: wseq = '{0, 1, 4};
			3: wseq = '{0, 4, 1};
			default: wseq = '{0, 1, 2, 3};
		endcase
		for (k = 0; k < 1 + (poke == 2); k++)
		begin
			foreach (wseq[i]) core.wr(addrs[wseq[i]], m[wseq[i]]);
			busy_cnt = 0;
			core.wr(op < 4 ? ADDR_OPB5 : ADDR_ARITH_CTRL, op < 4 ? m[5] : ctl);
			if (k == 0 && poke == 2)
			begin
				core.wr(ADDR_OPB0, m[0]);
				m_ctrl[7] = 1'b1;
				wait_idle();
			end
		end
		if (poke == 1)
		begin
			core.rd(ADDR_OPB0, got);
			m_ctrl[7] = 1'b1;
		end
		v = {m[3], m[2], m[1], m[0]};
		dv = {m[5], m[4]};
		m_ctrl[6] = 1'b0;
		case (op)
			1, 2:
			begin
				cyc = op == 1 ? 17 : 9;
				if (dv == 16'h0000)
					m_ctrl[6] = 1'b1;
				else if (op == 1)
					{m[5], m[4], m[3], m[2], m[1], m[0]} = {16'(v % dv), v / dv};
				else
					{m[5], m[4], m[1], m[0]} = {16'(v[15:0] % dv), v[15:0] / dv};
			end
			3:
			begin
				cyc = 11;
				v = {16'h0000, v[15:0]} * {16'h0000, dv};
				m_ctrl[6] = v > 32'h0000ffff;
			end
			4:
			begin
				cyc = 2 + (ctl[4:0] + 1) / 2;
				v = ctl[5] ? v >> ctl[4:0] : v << ctl[4:0];
				m_ctrl[5:0] = ctl[5:0];
			end
			default:
			begin
				m_ctrl[6] = v[31];
				for (k = 0; !v[31]; k++)
					v = v << 1;
				cyc = 3 + (k + 1) / 2;
				m_ctrl[5:0] = {ctl[5], 5'(k)};
			end
		endcase
		if (op > 2)
			{m[3], m[2], m[1], m[0]} = v;
		wait_idle();
		chk_cyc(busy_cnt, cyc);
		if (op < 3)
		begin
			rseq = wseq;
			rseq.push_back(5);
		end
		else
			rseq = '{0, 1, 2, 3};
		foreach (rseq[i])
		begin
			core.rd(addrs[rseq[i]], got);
			chk_byte(got, m[rseq[i]]);
		end
		core.rd(ADDR_ARITH_CTRL, got);
		chk_byte(got, m_ctrl);
		m_ctrl[7] = 1'b0;
	endtask : run_op
	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial
	begin
		rstn_i = 1'b0;
		n_fail = 0;
		checks = 0;
		busy_cnt = 0;
		seed = 44;
		m_ctrl = CTRL_RESET;
		ctl = 8'h00;
		op = 1;
		addrs = '{ADDR_OPB0, ADDR_OPB1, ADDR_OPB2, ADDR_OPB3, ADDR_OPB4, ADDR_OPB5};
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		core.rd(ADDR_ARITH_CTRL, got);
		chk_byte(got, CTRL_RESET);
		core.rd(8'h00, got);
		chk_byte(got, 8'h00);
		for (t = 0; t < 40; t++)
		begin
			foreach (m[i]) m[i] = $random(seed);
			ctl = $random(seed);
			op = t % 5 + 1;
			case (t)
				5: {op, m[4], m[5]} = {32'd1, 16'h0000};
				6: {op, m[4], m[5]} = {32'd2, 16'h0000};
				7: {op, ctl[4:0]} = {32'd4, 5'h01};
				8: {op, ctl[4:0]} = {32'd4, 5'h1f};
				9: {op, m[3][7]} = {32'd5, 1'b1};
				10: {op, m[1], m[5]} = {32'd3, 16'h0000};
				11: op = 1;
				12: op = 3;
				default: ;
			endcase
			if (op == 4 && ctl[4:0] == 5'h00)
				ctl[0] = 1'b1;
			if (op == 5)
				{ctl[4:0], m[0][0]} = {5'h00, 1'b1};
			run_op(t == 11 ? 1 : t == 12 ? 2 : 0);
		end
		give_verdict();
	end
endmodule : multiply_divide_coprocessor_tb_top
